/* File: design/spisp_defines.vh */
`ifndef SPISP_DEFINES_VH
`define SPISP_DEFINES_VH

// Register indexes; byte address is four times the index.
`define SPISP_P1_STAT_IDX 10'h220
`define SPISP_P1_CON_IDX 10'h222
`define SPISP_P1_BUF_IDX 10'h224
`define SPISP_P2_STAT_IDX 10'h226
`define SPISP_P2_CON_IDX 10'h228
`define SPISP_P2_BUF_IDX 10'h22A

// Reset values.
`define SPISP_STAT_RST 16'h0000
`define SPISP_CON_RST 16'h0000
`define SPISP_BUF_RST 16'h0000

// Status field positions.
`define SPISP_ST_EN 15
`define SPISP_ST_SIDL 13
`define SPISP_ST_ROV 6
`define SPISP_ST_TBF 1
`define SPISP_ST_RBF 0

// Control field positions.
`define SPISP_CN_FRAMING_ENABLE 14
`define SPISP_CN_FSD 13
`define SPISP_CN_OUTPUT_PIN_DISABLE 11
`define SPISP_CN_WORD_SIZE_SELECT 10
`define SPISP_CN_SMP 9
`define SPISP_CN_CKE 8
`define SPISP_CN_SELECT_PIN_ENABLE 7
`define SPISP_CN_CKP 6
`define SPISP_CN_MASTER_SELECT 5
`define SPISP_CN_SECONDARY_DIVIDER_HI 4
`define SPISP_CN_SECONDARY_DIVIDER_LO 2
`define SPISP_CN_PRIMARY_DIVIDER_HI 1
`define SPISP_CN_PRIMARY_DIVIDER_LO 0

// Word lengths in bits.
`define SPISP_BITS_BYTE 5'h08
`define SPISP_BITS_WORD 5'h10

// Engine states.
`define SPISP_S_IDLE 2'h0
`define SPISP_S_SYNC 2'h1
`define SPISP_S_RUN 2'h2

`endif

/* File: design/spisp_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "spisp_defines.vh"

module spisp_top #(
  parameter [9:0] STAT_IDX = `SPISP_P1_STAT_IDX,
  parameter [9:0] CON_IDX = `SPISP_P1_CON_IDX,
  parameter [9:0] BUF_IDX = `SPISP_P1_BUF_IDX
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial pins
  input wire shift_clock_pin_in,
  output reg shift_clock_pin_out,
  output reg shift_clock_pin_oe,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg serial_out_pin_oe,
  input wire select_low_pin_in,
  output reg select_low_pin_out,
  output reg select_low_pin_oe,
  // Power modes and interrupt
  input wire cpu_sleep,
  input wire cpu_idle,
  input wire port_irq_enable,
  input wire port_irq_flag_clear,
  output reg port_irq_flag,
  output reg port_irq
);

  // Half period of the shift clock in pclk cycles.
  function [9:0] half_period;
    input [1:0] pri;
    input [2:0] sec;
    reg [6:0] p;
    begin
      case (pri)
        2'h0: p = 7'h40;
        2'h1: p = 7'h10;
        2'h2: p = 7'h04;
        default: p = 7'h01;
      endcase
      half_period = p * (4'h8 - {1'b0, sec});
    end
  endfunction

  reg [15:0] ctl_q;
  reg en_q, sidl_q, rov_q, tbf_q, rbf_q;
  reg [15:0] tx_q, rx_q, sr_q;
  reg [1:0] st_q;
  reg [4:0] cnt_q;
  reg samp_q, have_q, fin_q;
  reg act_q, prev_q;
  reg [9:0] div_q;
  reg fs_q, sync_done_q;

  wire framing_enable = ctl_q[`SPISP_CN_FRAMING_ENABLE];
  wire fsd = ctl_q[`SPISP_CN_FSD];
  wire word_size_select = ctl_q[`SPISP_CN_WORD_SIZE_SELECT];
  wire cke = ctl_q[`SPISP_CN_CKE];
  wire select_pin_enable = ctl_q[`SPISP_CN_SELECT_PIN_ENABLE];
  wire idle_level_select = ctl_q[`SPISP_CN_CKP];
  wire master = ctl_q[`SPISP_CN_MASTER_SELECT];
  wire [4:0] nbits = word_size_select ? `SPISP_BITS_WORD : `SPISP_BITS_BYTE;
  wire [9:0] half = half_period(ctl_q[`SPISP_CN_PRIMARY_DIVIDER_HI:`SPISP_CN_PRIMARY_DIVIDER_LO],
    ctl_q[`SPISP_CN_SECONDARY_DIVIDER_HI:`SPISP_CN_SECONDARY_DIVIDER_LO]);

  // APB decode; a write or read takes effect at the access edge.
  wire acc = psel & penable & pready;
  wire [9:0] idx = paddr[11:2];
  wire hit_stat = idx == STAT_IDX;
  wire hit_con = idx == CON_IDX;
  wire hit_buf = idx == BUF_IDX;
  wire wr_stat = acc & pwrite & hit_stat;
  wire wr_con = acc & pwrite & hit_con;
  wire wr_buf = acc & pwrite & hit_buf;
  wire rd_buf = acc & ~pwrite & hit_buf;
  wire size_chg = wr_con & (pwdata[`SPISP_CN_WORD_SIZE_SELECT] != word_size_select);

  // Engine abort clears counters; stall merely freezes them.
  wire ss_high = ~master & select_pin_enable & ~framing_enable & select_low_pin_in;
  wire abort = ~en_q | cpu_sleep | size_chg | ss_high;
  wire stall = rov_q | (cpu_idle & sidl_q);

  // Edge events of the shift clock, own or external.
  wire mtick = master & (st_q != `SPISP_S_IDLE) & (div_q == 10'h001);
  wire act_in = shift_clock_pin_in ^ idle_level_select;
  wire lead = master ? (mtick & ~act_q) : (act_in & ~prev_q);
  wire trail = master ? (mtick & act_q) : (~act_in & prev_q);
  wire tx_edge = cke ? trail : lead;
  wire smp_edge = cke ? lead : trail;
  wire running = (st_q == `SPISP_S_RUN) & ~stall;
  wire last = running & smp_edge & (cnt_q == nbits - 5'h01);
  wire [15:0] rx_word = {sr_q[14:0], serial_in_pin};
  wire [15:0] rx_mask = word_size_select ? rx_word : {8'h00, rx_word[7:0]};

  // Pending word enters the shift register between words.
  wire slot = (cnt_q == 5'h00) & ~have_q;
  wire m_start = master & (st_q == `SPISP_S_IDLE) & tbf_q;
  wire s_load = ~master & slot & tbf_q & ~running;
  wire load_tx = en_q & ~abort & ~stall & ((m_start) | s_load | (last & tbf_q));

  // Status and control registers.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q <= `SPISP_CON_RST;
      en_q <= 1'b0;
      sidl_q <= 1'b0;
    end
    else
    begin
      if (wr_con)
        ctl_q <= pwdata[15:0];
      if (wr_stat)
      begin
        en_q <= pwdata[`SPISP_ST_EN];
        sidl_q <= pwdata[`SPISP_ST_SIDL];
      end
    end
  end

  // Buffers and their flags; hardware set wins over software clear, but a word-size change clears all flags.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_q <= `SPISP_BUF_RST;
      rx_q <= `SPISP_BUF_RST;
      tbf_q <= 1'b0;
      rbf_q <= 1'b0;
      rov_q <= 1'b0;
    end
    else if (size_chg)
    begin
      tbf_q <= 1'b0;
      rbf_q <= 1'b0;
      rov_q <= 1'b0;
    end
    else
    begin
      if (wr_buf)
      begin
        tx_q <= pwdata[15:0];
        tbf_q <= 1'b1;
      end
      else if (load_tx)
        tbf_q <= 1'b0;
      if (last & rbf_q & ~rd_buf)
        rov_q <= 1'b1;
      else if (rd_buf | (wr_stat & ~pwdata[`SPISP_ST_ROV]))
        rov_q <= 1'b0;
      if (last & (~rbf_q | rd_buf))
      begin
        rx_q <= rx_mask;
        rbf_q <= 1'b1;
      end
      else if (rd_buf)
        rbf_q <= 1'b0;
    end
  end

  // Shift engine.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_q <= 16'h0000;
      st_q <= `SPISP_S_IDLE;
      cnt_q <= 5'h00;
      samp_q <= 1'b0;
      have_q <= 1'b0;
      fin_q <= 1'b0;
      act_q <= 1'b0;
      prev_q <= 1'b0;
      div_q <= 10'h001;
      fs_q <= 1'b0;
      sync_done_q <= 1'b0;
    end
    else if (abort)
    begin
      st_q <= `SPISP_S_IDLE;
      cnt_q <= 5'h00;
      have_q <= 1'b0;
      fin_q <= 1'b0;
      act_q <= 1'b0;
      prev_q <= act_in;
      div_q <= 10'h001;
      fs_q <= 1'b0;
      sync_done_q <= 1'b0;
    end
    else if (!stall)
    begin
      prev_q <= act_in;
      if (master && st_q != `SPISP_S_IDLE)
      begin
        div_q <= mtick ? half : div_q - 10'h001;
        if (mtick)
          act_q <= ~act_q;
      end
      else
        div_q <= half;
      if (load_tx)
        sr_q <= tx_q;
      else if (running && tx_edge && have_q)
      begin
        sr_q <= {sr_q[14:0], samp_q};
        have_q <= 1'b0;
      end
      case (st_q)
        `SPISP_S_IDLE:
        begin
          if (m_start || (!master && en_q))
            st_q <= framing_enable ? `SPISP_S_SYNC : `SPISP_S_RUN;
          sync_done_q <= 1'b0;
        end
        `SPISP_S_SYNC:
        begin
          if (!fsd)
          begin
            if (lead && !sync_done_q && (master || tbf_q))
            begin
              fs_q <= ~fs_q;
              sync_done_q <= fs_q;
            end
          end
          else if (select_low_pin_in)
            sync_done_q <= 1'b1;
          if (sync_done_q && tx_edge && !fs_q)
            st_q <= `SPISP_S_RUN;
        end
        `SPISP_S_RUN:
        begin
          if (smp_edge)
          begin
            samp_q <= serial_in_pin;
            have_q <= ~last;
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
          end
          if (last)
          begin
            fin_q <= master;
            if (!master && framing_enable)
            begin
              st_q <= `SPISP_S_SYNC;
              sync_done_q <= 1'b0;
            end
          end
          if (master && trail && (fin_q || last))
          begin
            st_q <= `SPISP_S_IDLE;
            fin_q <= 1'b0;
          end
        end
        default: st_q <= `SPISP_S_IDLE;
      endcase
    end
  end

  // Pin and interrupt outputs, all registered.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_clock_pin_out <= 1'b0;
      shift_clock_pin_oe <= 1'b0;
      serial_out_pin <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      select_low_pin_out <= 1'b0;
      select_low_pin_oe <= 1'b0;
      port_irq_flag <= 1'b0;
      port_irq <= 1'b0;
    end
    else
    begin
      shift_clock_pin_out <= act_q ^ idle_level_select;
      shift_clock_pin_oe <= en_q & master;
      serial_out_pin <= word_size_select ? sr_q[15] : sr_q[7];
      serial_out_pin_oe <= en_q & ~ctl_q[`SPISP_CN_OUTPUT_PIN_DISABLE] & ~ss_high;
      select_low_pin_out <= fs_q;
      select_low_pin_oe <= en_q & framing_enable & ~fsd;
      if (last)
        port_irq_flag <= 1'b1;
      else if (port_irq_flag_clear)
        port_irq_flag <= 1'b0;
      port_irq <= (port_irq_flag | last) & port_irq_enable;
    end
  end

  // APB answer: no wait states, so every transfer takes two edges.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~(hit_stat | hit_con | hit_buf);
      if (psel && !penable && !pwrite)
      begin
        if (hit_stat)
          prdata <= {16'h0000, en_q, 1'b0, sidl_q, 6'h00, rov_q, 4'h0, tbf_q, rbf_q};
        else if (hit_con)
          prdata <= {16'h0000, ctl_q};
        else if (hit_buf)
          prdata <= {16'h0000, rx_q};
        else
          prdata <= 32'h00000000;
      end
    end
  end

endmodule // spisp_top

`default_nettype wire

/* File: tb/spisp_props.sv */
`timescale 1ns/1ps
`default_nettype none
module spisp_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire shift_clock_pin_oe,
  input wire serial_out_pin_oe,
  input wire select_low_pin_in,
  input wire port_irq_enable,
  input wire port_irq_flag,
  input wire port_irq
);
  logic [15:0] ctl_q;
  wire slv_ss = !ctl_q[5] && ctl_q[7] && !ctl_q[14];
  // The control word is shadowed from the bus so pin rules can be judged here.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_q <= 16'h0000;
    else if (psel && penable && pready && pwrite && paddr == 12'h888)
      ctl_q <= pwdata[15:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("answer without setup");
  a_err_data: assert property (pslverr && !pwrite |-> pready && prdata == 32'h00000000)
    else $error("refused read not clean");
  a_irq_gate: assert property (port_irq |-> $past(port_irq_enable) && ($past(port_irq_flag) || port_irq_flag))
    else $error("interrupt without enabled flag");
  a_out_off: assert property ($past(ctl_q[11]) |-> !serial_out_pin_oe)
    else $error("serial output driven while disabled");
  a_clk_slave: assert property (!ctl_q[5] && !$past(ctl_q[5]) |-> !shift_clock_pin_oe)
    else $error("shift clock driven in slave mode");
  a_sel_release: assert property ((slv_ss && select_low_pin_in)[*4] |-> !serial_out_pin_oe)
    else $error("serial output driven while deselected");
endmodule // spisp_props
bind spisp_top spisp_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .shift_clock_pin_oe, .serial_out_pin_oe, .select_low_pin_in,
  .port_irq_enable, .port_irq_flag, .port_irq);
`default_nettype wire

/* File: tb/spisp_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spisp_slave_model (
  // Serial link
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Bench side
  input wire logic load,
  input wire logic wide,
  input wire logic [15:0] reply,
  output logic [15:0] got
);
  logic [15:0] tx;
  initial miso = 1'b0;
  // Between frames the line flips, so a stale bit can never pass for data.
  always @(posedge sck or posedge load)
  begin
    if (load)
    begin
      tx <= reply;
      miso <= ~miso;
    end
    else
    begin
      miso <= wide ? tx[15] : tx[7];
      tx <= tx << 1;
    end
  end
  always @(negedge sck)
    got <= {got[14:0], mosi};
endmodule // spisp_slave_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sck, mosi, miso, sel_n, sleep, idle, irq_en, irq_clr, irq_flag, irq, load, wide;
  logic sck_in, sck_oe, sdo_oe, fs_out, fs_oe;
  wire link_sck;
  logic [15:0] reply, got, r;
  logic [45:0] rows [0:6];
  integer bad_count, checks_done, i, n, k;
  spisp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .shift_clock_pin_in(sck_in), .shift_clock_pin_out(sck), .shift_clock_pin_oe(sck_oe),
    .serial_in_pin(miso), .serial_out_pin(mosi), .serial_out_pin_oe(sdo_oe),
    .select_low_pin_in(sel_n), .select_low_pin_out(fs_out), .select_low_pin_oe(fs_oe),
    .cpu_sleep(sleep), .cpu_idle(idle), .port_irq_enable(irq_en), .port_irq_flag_clear(irq_clr),
    .port_irq_flag(irq_flag), .port_irq(irq));
  // The peer sees whichever side makes the shift clock; the idle side holds low.
  assign link_sck = sck | sck_in;
  spisp_slave_model peer (.sck(link_sck), .mosi, .miso, .load, .wide, .reply, .got);
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
    end
  end
  endtask
  task apb(input [11:0] a, input w, input [15:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n >= 50)
      bad_count = bad_count + 1;
    r = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task wait_flag;
  begin
    n = 0;
    while (irq_flag !== 1'b1 && n < 400)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n >= 400)
      bad_count = bad_count + 1;
    // The peer takes its last bit at the clock fall launched with the flag.
    @(posedge pclk);
  end
  endtask
  task pulses;
  begin
    repeat (8)
    begin
      sck_in <= 1'b1;
      repeat (4) @(posedge pclk);
      sck_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  end
  endtask
  task load_peer(input [15:0] v);
  begin
    reply <= v;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
  end
  endtask
  task clr_flag;
  begin
    irq_clr <= 1'b1;
    @(posedge pclk);
    irq_clr <= 1'b0;
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    {psel, penable, pwrite, paddr, pwdata, sleep, idle, irq_en, irq_clr, load, wide, reply, sck_in} = 0;
    sel_n = 1'b1;
    presetn = 1'b0;
    rows[0] = {12'h880, 1'b0, 16'h0000, 16'h0000, 1'b0};
    rows[1] = {12'h888, 1'b0, 16'h0000, 16'h0000, 1'b0};
    rows[2] = {12'h890, 1'b0, 16'h0000, 16'h0000, 1'b0};
    rows[3] = {12'h888, 1'b1, 16'h0880, 16'h0000, 1'b0};
    rows[4] = {12'h888, 1'b0, 16'h0000, 16'h0880, 1'b0};
    rows[5] = {12'h000, 1'b0, 16'h0000, 16'h0000, 1'b1};
    rows[6] = {12'h8FC, 1'b1, 16'h1234, 16'h0000, 1'b1};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
    begin
      apb(rows[i][45:34], rows[i][33], rows[i][32:17]);
      if (!rows[i][33])
        chk(r, rows[i][16:1], "rd");
      chk(e, rows[i][0], "err");
    end
    // Master, byte words, shift clock half period of two cycles.
    apb(12'h888, 1'b1, 16'h003B);
    apb(12'h880, 1'b1, 16'h8000);
    for (i = 0; i < 2; i = i + 1)
    begin
      irq_en <= i[0];
      load_peer(16'h00A5 + i[15:0]);
      apb(12'h890, 1'b1, 16'h003C + i[15:0]);
      wait_flag;
      chk(got[7:0], 8'h3C + i[7:0], "sent");
      @(posedge pclk);
      chk(irq, i[0], "irq");
      clr_flag;
      apb(12'h880, 1'b0, 16'h0000);
      chk(r, i ? 16'h8041 : 16'h8001, "stat");
    end
    chk(sck_oe, 1'b1, "sckoe");
    chk(sdo_oe, 1'b1, "sdooe");
    apb(12'h888, 1'b1, 16'h083B);
    repeat (2) @(posedge pclk);
    chk(sdo_oe, 1'b0, "sdooff");
    apb(12'h888, 1'b1, 16'h003B);
    apb(12'h890, 1'b0, 16'h0000);
    chk(r, 16'h00A5, "rxbuf");
    apb(12'h880, 1'b1, 16'hA000);
    apb(12'h880, 1'b0, 16'h0000);
    chk(r, 16'hA000, "stat2");
    idle <= 1'b1;
    load_peer(16'h0066);
    apb(12'h890, 1'b1, 16'h005A);
    repeat (100) @(posedge pclk);
    chk(irq_flag, 1'b0, "idlestop");
    idle <= 1'b0;
    wait_flag;
    chk(got[7:0], 8'h5A, "idlerun");
    clr_flag;
    apb(12'h880, 1'b1, 16'h0000);
    apb(12'h888, 1'b1, 16'h043B);
    apb(12'h880, 1'b0, 16'h0000);
    chk(r, 16'h0000, "modeclr");
    apb(12'h880, 1'b1, 16'h8000);
    wide <= 1'b1;
    load_peer(16'hC3E1);
    apb(12'h890, 1'b1, 16'h9A5B);
    wait_flag;
    chk(got, 16'h9A5B, "sent16");
    apb(12'h890, 1'b0, 16'h0000);
    chk(r, 16'hC3E1, "rx16");
    clr_flag;
    load_peer(16'h0F0F);
    apb(12'h890, 1'b1, 16'h1111);
    repeat (6) @(posedge pclk);
    sleep <= 1'b1;
    repeat (20) @(posedge pclk);
    sleep <= 1'b0;
    repeat (300) @(posedge pclk);
    chk(irq_flag, 1'b0, "abort");
    apb(12'h888, 1'b0, 16'h0000);
    chk(r, 16'h043B, "keep");
    // Framed master: the sync pulse spans one shift clock of four pclk cycles.
    apb(12'h880, 1'b1, 16'h0000);
    apb(12'h888, 1'b1, 16'h403B);
    apb(12'h880, 1'b1, 16'h8000);
    wide <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(fs_oe, 1'b1, "fsoe");
    apb(12'h890, 1'b1, 16'h0077);
    k = 0;
    repeat (40)
    begin
      @(posedge pclk);
      if (fs_out === 1'b1)
        k = k + 1;
    end
    chk(k, 32'd4, "fswidth");
    wait_flag;
    chk(got[7:0], 8'h77, "framed");
    clr_flag;
    // Slave with select gating, clocked from the bench.
    apb(12'h880, 1'b1, 16'h0000);
    apb(12'h888, 1'b1, 16'h0080);
    apb(12'h890, 1'b0, 16'h0000);
    apb(12'h880, 1'b1, 16'h8000);
    apb(12'h890, 1'b1, 16'h00C6);
    pulses;
    chk(irq_flag, 1'b0, "ssgate");
    chk(sdo_oe, 1'b0, "ssoff");
    load_peer(16'h0081);
    sel_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(sdo_oe, 1'b1, "sson");
    pulses;
    wait_flag;
    chk(got[7:0], 8'hC6, "slvsent");
    apb(12'h890, 1'b0, 16'h0000);
    chk(r, 16'h0081, "slvrx");
    sel_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(sdo_oe, 1'b0, "ssrel");
    test_done;
  end
endmodule // tb_top
`default_nettype wire
